// File: src/fldc_regs.sv
// floppy logical device configuration bank with drive-interface pin shaping
// assumes controller core signals share this clock; pins resolved outside
//
// Contract
// - registers reset to defaults only on hard reset; soft reset leaves them.
// - mode bit 0 selects normal (0) or enhanced floppy mode (1).
// - mode bit 1: 0 enables burst dma, 1 selects non-burst (default).
// - mode bits 3:2 pick AT, reserved, PS/2 or Model 30 interface.
// - mode bit 4 swaps drive selects 0/1 and motor selects 0/1.
// - shutdown accepts only four host writes, tri-states pins except six.
// - mode bit 6 makes drive outputs open drain (0) or push-pull (1).
// - mode bit 7 tri-states controller outputs; port-routed pins unaffected.
// - option bits 1:0 reserved; bits 3:2 normal, user (acts as normal), force 1, force 0.
// - type register holds four two-bit drive types; resets to all ones.
// - location after type register is read-only and reads zero.
// - per-drive register: type 1:0, rate table 4:3, precomp 6; others zero.
// - second per-drive register matches first in layout and default.
// - precomp disable 0 enables precompensation, 1 disables it.
// - drive type pair maps density, rate0 and rate1 onto two pins.
`timescale 1ns/1ps
`default_nettype none

module fldc_regs
  import fldc_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic [7:0]    address,
  input  wire logic [7:0]    writeData,
  input  wire logic          writeStrobe,
  input  wire logic          readStrobe,
  output logic      [7:0]    readData,
  input  wire logic          hostIoWrite,
  input  wire fldc_target_t  hostIoTarget,
  output logic               hostIoAccept,
  input  wire fldc_core_t    core,
  output fldc_pins_t         pinOut,
  output fldc_pins_t         pinOeLow,
  output logic               enhancedMode,
  output logic               burstDmaEnable,
  output fldc_if_mode_t      interfaceMode,
  output logic               coreShutdown,
  output logic [1:0]         mediaIdPolarity,
  output logic [1:0]         bootDrive,
  output logic [7:0]         driveTypeTable,
  output logic [1:0]         rateTableSelect0,
  output logic [1:0]         rateTableSelect1,
  output logic               precompEnable0,
  output logic               precompEnable1
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic regHit(input logic [7:0] addr,
                                  input logic [7:0] offset);
    regHit = (addr == offset);
  endfunction : regHit

  // open-drain pins release a high level; enable is active low
  function automatic logic pinRelease(input logic value,
                                      input logic exempt,
                                      input logic [7:0] modeReg);
    logic openDrain;
    openDrain  = ~modeReg[FLDC_MODE_PUSHPULL];
    pinRelease = modeReg[FLDC_MODE_TRISTATE]
               | (modeReg[FLDC_MODE_SHUTDOWN] & ~exempt)
               | (openDrain & value);
  endfunction : pinRelease

  // ----------------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------------
  logic [7:0] floppyModeControl;
  logic [7:0] floppyOptionControl;
  logic [7:0] driveTypeTableReg;
  logic [7:0] driveParams [2];

  // only the hard reset loads their defaults; no soft reset reaches them
  // every mode bit is stored as written; none is reserved
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      floppyModeControl <= FLDC_RST_MODE;
    end
    else if (writeStrobe && regHit(address, FLDC_OFF_MODE))
    begin
      floppyModeControl <= writeData;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      floppyOptionControl <= FLDC_RST_OPTION;
    end
    else if (writeStrobe && regHit(address, FLDC_OFF_OPTION))
    begin
      // reserved low bits are kept at zero
      floppyOptionControl <= writeData & FLDC_MASK_OPTION;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      driveTypeTableReg <= FLDC_RST_TYPE;
    end
    else if (writeStrobe && regHit(address, FLDC_OFF_TYPE))
    begin
      driveTypeTableReg <= writeData;
    end
  end

  // both per-drive registers share one layout and default
  genvar gDrive;
  generate
    for (gDrive = 0; gDrive < 2; gDrive++)
    begin : gDriveParams
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
        begin
          driveParams[gDrive] <= FLDC_RST_DRIVE;
        end
        else if (writeStrobe &&
                 regHit(address, FLDC_OFF_DRIVE0 + 8'(gDrive)))
        begin
          driveParams[gDrive] <= writeData & FLDC_MASK_DRIVE;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  logic [7:0] next_readData;

  always_comb
  begin
    next_readData = FLDC_READ_ZERO;
    if (readStrobe)
    begin
      if (regHit(address, FLDC_OFF_MODE))
      begin
        next_readData = floppyModeControl;
      end
      else if (regHit(address, FLDC_OFF_OPTION))
      begin
        next_readData = floppyOptionControl;
      end
      else if (regHit(address, FLDC_OFF_TYPE))
      begin
        next_readData = driveTypeTableReg;
      end
      else if (regHit(address, FLDC_OFF_RESERVED))
      begin
        next_readData = FLDC_READ_ZERO;
      end
      else if (regHit(address, FLDC_OFF_DRIVE0))
      begin
        next_readData = driveParams[0];
      end
      else if (regHit(address, FLDC_OFF_DRIVE1))
      begin
        next_readData = driveParams[1];
      end
      else
      begin
        // unmapped indices read zero, like the reserved slot
        next_readData = FLDC_READ_ZERO;
      end
    end
  end

  // data stands only in the cycle after the strobe
  // a zero idle value keeps stale data off the port between reads
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      readData <= FLDC_READ_ZERO;
    end
    else
    begin
      readData <= next_readData;
    end
  end

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  assign enhancedMode   = floppyModeControl[FLDC_MODE_ENHANCED];
  assign burstDmaEnable = ~floppyModeControl[FLDC_MODE_NONBURST];
  assign interfaceMode  = fldc_if_mode_t'(
                            {floppyModeControl[FLDC_MODE_IDENT],
                             floppyModeControl[FLDC_MODE_MODUL]});
  assign coreShutdown   = floppyModeControl[FLDC_MODE_SHUTDOWN];

  // ----------------------------------------------------------------------
  // option and per-drive decode
  // ----------------------------------------------------------------------
  assign mediaIdPolarity  = floppyOptionControl[FLDC_OPT_MEDIA_LO +: 2];
  assign bootDrive        = floppyOptionControl[FLDC_OPT_BOOT_LO +: 2];
  assign driveTypeTable   = driveTypeTableReg;
  assign rateTableSelect0 = driveParams[0][FLDC_DRV_RATE_LO +: 2];
  assign rateTableSelect1 = driveParams[1][FLDC_DRV_RATE_LO +: 2];
  assign precompEnable0   = ~driveParams[0][FLDC_DRV_PRECOMP];
  assign precompEnable1   = ~driveParams[1][FLDC_DRV_PRECOMP];

  // ----------------------------------------------------------------------
  // host write gating
  // ----------------------------------------------------------------------
  logic targetAllowed;

  always_comb
  begin
    unique case (hostIoTarget)
      FLDC_TGT_DIGITAL_OUT,
      FLDC_TGT_TAPE_DRIVE,
      FLDC_TGT_RATE_SELECT,
      FLDC_TGT_CONFIG_CTRL: targetAllowed = 1'b1;
      default:              targetAllowed = 1'b0;
    endcase
  end

  // in shutdown only the four core-side control registers stay writable
  assign hostIoAccept = hostIoWrite & (~coreShutdown | targetAllowed);

  // ----------------------------------------------------------------------
  // density forcing and type mapping
  // ----------------------------------------------------------------------
  // forcing acts on the density term before type mapping
  fldc_dens_t densityMode;
  logic       densityLevel;
  logic [7:0] activeParams;
  logic       typeBit0;
  logic       typeBit1;
  logic       next_densityA;
  logic       next_densityB;

  assign densityMode  = fldc_dens_t'(
                          floppyOptionControl[FLDC_OPT_DENS_LO +: 2]);
  assign activeParams = driveParams[core.driveIndex];
  // type bits sit swapped in the per-drive register
  assign typeBit0     = activeParams[FLDC_DRV_TYPE_BIT0];
  assign typeBit1     = activeParams[FLDC_DRV_TYPE_BIT1];

  always_comb
  begin
    unique case (densityMode)
      FLDC_DENS_FORCE1: densityLevel = 1'b1;
      FLDC_DENS_FORCE0: densityLevel = 1'b0;
      default:          densityLevel = core.densitySelect;
    endcase
  end

  always_comb
  begin
    unique case ({typeBit0, typeBit1})
      2'h0:
      begin
        next_densityA = densityLevel;
        next_densityB = core.rateBit0;
      end
      2'h1:
      begin
        next_densityA = core.rateBit1;
        next_densityB = core.rateBit0;
      end
      2'h2:
      begin
        next_densityA = ~densityLevel;
        next_densityB = core.rateBit0;
      end
      default:
      begin
        next_densityA = core.rateBit0;
        next_densityB = core.rateBit1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // pin shaping
  // ----------------------------------------------------------------------
  fldc_pins_t next_pinOut;
  fldc_pins_t next_pinOeLow;
  logic       swapDrives;

  assign swapDrives = floppyModeControl[FLDC_MODE_SWAP];

  always_comb
  begin
    next_pinOut.densityOutA = next_densityA;
    next_pinOut.densityOutB = next_densityB;
    next_pinOut.otherOut    = core.otherOut;
    if (swapDrives)
    begin
      next_pinOut.driveSelectLow = {core.driveSelectLow[0],
                                    core.driveSelectLow[1]};
      next_pinOut.motorOnLow     = {core.motorOnLow[0],
                                    core.motorOnLow[1]};
    end
    else
    begin
      next_pinOut.driveSelectLow = core.driveSelectLow;
      next_pinOut.motorOnLow     = core.motorOnLow;
    end
  end

  // densities, selects and motors stay driven through shutdown
  always_comb
  begin
    next_pinOeLow.densityOutA =
      pinRelease(next_pinOut.densityOutA, 1'b1, floppyModeControl);
    next_pinOeLow.densityOutB =
      pinRelease(next_pinOut.densityOutB, 1'b1, floppyModeControl);
    for (int i = 0; i < 2; i++)
    begin
      next_pinOeLow.driveSelectLow[i] =
        pinRelease(next_pinOut.driveSelectLow[i], 1'b1,
                   floppyModeControl);
    end
    for (int k = 0; k < 2; k++)
    begin
      next_pinOeLow.motorOnLow[k] =
        pinRelease(next_pinOut.motorOnLow[k], 1'b1,
                   floppyModeControl);
    end
    for (int j = 0; j < FLDC_OTHER_PINS; j++)
    begin
      next_pinOeLow.otherOut[j] =
        pinRelease(next_pinOut.otherOut[j], 1'b0,
                   floppyModeControl);
    end
  end

  // registered pins avoid glitches while mode bits change;
  // parallel-port floppy pins are outside this block, so bits 6/7 skip them
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pinOut <= '1;
    end
    else
    begin
      pinOut <= next_pinOut;
    end
  end

  // enables reset released, so no pin is driven before the first edge
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pinOeLow <= '1;
    end
    else
    begin
      pinOeLow <= next_pinOeLow;
    end
  end

endmodule : fldc_regs

`default_nettype wire

// File: src/fldc_pkg.sv
// constants, field positions and carrier types of the floppy logical device
// configuration bank; assumes an 8-bit configuration index and data path
package fldc_pkg;

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLDC_OFF_MODE     = 8'hF0;
  localparam logic [7:0] FLDC_OFF_OPTION   = 8'hF1;
  localparam logic [7:0] FLDC_OFF_TYPE     = 8'hF2;
  localparam logic [7:0] FLDC_OFF_RESERVED = 8'hF3;
  localparam logic [7:0] FLDC_OFF_DRIVE0   = 8'hF4;
  localparam logic [7:0] FLDC_OFF_DRIVE1   = 8'hF5;

  // ----------------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLDC_RST_MODE     = 8'h0E;
  localparam logic [7:0] FLDC_RST_OPTION   = 8'h00;
  localparam logic [7:0] FLDC_RST_TYPE     = 8'hFF;
  localparam logic [7:0] FLDC_RST_DRIVE    = 8'h00;
  localparam logic [7:0] FLDC_MASK_OPTION  = 8'hFC;
  localparam logic [7:0] FLDC_MASK_DRIVE   = 8'h5B;
  localparam logic [7:0] FLDC_READ_ZERO    = 8'h00;

  // ----------------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------------
  localparam int FLDC_MODE_ENHANCED  = 0;
  localparam int FLDC_MODE_NONBURST  = 1;
  localparam int FLDC_MODE_MODUL     = 2;
  localparam int FLDC_MODE_IDENT     = 3;
  localparam int FLDC_MODE_SWAP      = 4;
  localparam int FLDC_MODE_SHUTDOWN  = 5;
  localparam int FLDC_MODE_PUSHPULL  = 6;
  localparam int FLDC_MODE_TRISTATE  = 7;

  // ----------------------------------------------------------------------
  // option register and per-drive fields
  // ----------------------------------------------------------------------
  localparam int FLDC_OPT_DENS_LO    = 2;
  localparam int FLDC_OPT_MEDIA_LO   = 4;
  localparam int FLDC_OPT_BOOT_LO    = 6;
  localparam int FLDC_DRV_TYPE_BIT1  = 0;
  localparam int FLDC_DRV_TYPE_BIT0  = 1;
  localparam int FLDC_DRV_RATE_LO    = 3;
  localparam int FLDC_DRV_PRECOMP    = 6;
  localparam int FLDC_OTHER_PINS     = 5;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FLDC_IF_MODEL30  = 2'h0,
    FLDC_IF_PS2      = 2'h1,
    FLDC_IF_RESERVED = 2'h2,
    FLDC_IF_AT       = 2'h3
  } fldc_if_mode_t;

  typedef enum logic [1:0] {
    FLDC_DENS_NORMAL = 2'h0,
    FLDC_DENS_USER   = 2'h1,
    FLDC_DENS_FORCE1 = 2'h2,
    FLDC_DENS_FORCE0 = 2'h3
  } fldc_dens_t;

  typedef enum logic [2:0] {
    FLDC_TGT_DIGITAL_OUT = 3'h0,
    FLDC_TGT_TAPE_DRIVE  = 3'h1,
    FLDC_TGT_RATE_SELECT = 3'h2,
    FLDC_TGT_CONFIG_CTRL = 3'h3,
    FLDC_TGT_OTHER       = 3'h4
  } fldc_target_t;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                 driveSelectLow;
    logic [1:0]                 motorOnLow;
    logic                       densitySelect;
    logic                       rateBit0;
    logic                       rateBit1;
    logic                       driveIndex;
    logic [FLDC_OTHER_PINS-1:0] otherOut;
  } fldc_core_t;

  typedef struct packed {
    logic                       densityOutA;
    logic                       densityOutB;
    logic [1:0]                 driveSelectLow;
    logic [1:0]                 motorOnLow;
    logic [FLDC_OTHER_PINS-1:0] otherOut;
  } fldc_pins_t;

endpackage : fldc_pkg

// File: test/fldc_assertions.sv
// checker for the floppy configuration bank: reads, mode outputs, pins
// assumes only the bank's ports; bound to the bank after endmodule
`timescale 1ns/1ps
`default_nettype none

module fldc_assertions
  import fldc_pkg::*;
(
  input wire logic          clock,
  input wire logic          reset,
  input wire logic [7:0]    address,
  input wire logic [7:0]    writeData,
  input wire logic          writeStrobe,
  input wire logic          readStrobe,
  input wire logic [7:0]    readData,
  input wire logic          hostIoWrite,
  input wire fldc_target_t  hostIoTarget,
  input wire logic          hostIoAccept,
  input wire fldc_core_t    core,
  input wire fldc_pins_t    pinOut,
  input wire fldc_pins_t    pinOeLow,
  input wire logic          enhancedMode,
  input wire logic          burstDmaEnable,
  input wire fldc_if_mode_t interfaceMode,
  input wire logic          coreShutdown
);
  // ----------------------------------------------------------------
  // mode shadow, so pin rules can be judged without the bank's state
  // ----------------------------------------------------------------
  logic [7:0] modeCopy;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      modeCopy <= FLDC_RST_MODE;
    else if (writeStrobe && address == FLDC_OFF_MODE)
      modeCopy <= writeData;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reserved_reads_zero: assert property (
    readStrobe && address == FLDC_OFF_RESERVED |=> readData == 8'h00)
    else $error("reserved slot read not zero");
  a_drive_pad_zero: assert property (
    readStrobe && address[7:1] == 7'h7A |=> (readData & 8'hA4) == 8'h00)
    else $error("per-drive pad bits not zero");
  a_option_pad_zero: assert property (
    readStrobe && address == FLDC_OFF_OPTION |=> readData[1:0] == 2'h0)
    else $error("option low bits not zero");
  a_mode_fields: assert property (enhancedMode == modeCopy[0]
    && burstDmaEnable == !modeCopy[1] && interfaceMode == modeCopy[3:2]
    && coreShutdown == modeCopy[5]) else $error("mode outputs wrong");
  a_write_gate: assert property (hostIoAccept == (hostIoWrite &&
    (!coreShutdown || hostIoTarget <= FLDC_TGT_CONFIG_CTRL)))
    else $error("host write gate wrong");
  a_shutdown_float: assert property (
    !$past(reset) && $past(modeCopy[5]) |-> &pinOeLow.otherOut)
    else $error("other pins driven in shutdown");
  a_outputs_float: assert property (
    !$past(reset) && $past(modeCopy[7]) |-> &pinOeLow)
    else $error("pins driven while floated");
  a_swap_selects: assert property (!$past(reset) && !$past(modeCopy[7])
    |-> pinOut.driveSelectLow == ($past(modeCopy[4]) ?
    {$past(core.driveSelectLow[0]), $past(core.driveSelectLow[1])} :
    $past(core.driveSelectLow)))
    else $error("drive select swap wrong");
  a_open_drain: assert property (
    !$past(reset) && $past(modeCopy[7:6]) == 2'h0
    |-> pinOeLow.motorOnLow == pinOut.motorOnLow)
    else $error("open drain enable wrong");
  a_push_pull: assert property (
    !$past(reset) && $past(modeCopy[7:6]) == 2'h1
    |-> pinOeLow.driveSelectLow == 2'h0 && pinOeLow.motorOnLow == 2'h0)
    else $error("push-pull enable wrong");

  c_float_write: cover property (writeStrobe && writeData[7]
    && address == FLDC_OFF_MODE);
  c_refused: cover property (hostIoWrite && !hostIoAccept);
  c_drive_read: cover property (readStrobe && address == FLDC_OFF_DRIVE1);
endmodule : fldc_assertions

bind fldc_regs fldc_assertions i_fldc_assertions (.clock, .reset, .address,
  .writeData, .writeStrobe, .readStrobe, .readData, .hostIoWrite,
  .hostIoTarget, .hostIoAccept, .core, .pinOut, .pinOeLow, .enhancedMode,
  .burstDmaEnable, .interfaceMode, .coreShutdown);

`default_nettype wire

// File: test/fldc_drive_model.sv
// drive-side model: resolves each drive-interface line as the drives see it
// assumes a pull-up on every line, so a released line reads high
`timescale 1ns/1ps
`default_nettype none

module fldc_drive_model
  import fldc_pkg::*;
(
  input  wire fldc_pins_t pinOut,
  input  wire fldc_pins_t pinOeLow,
  output var  fldc_pins_t lineLevel
);
  // open drain and push-pull both land on the driven level here
  assign lineLevel = fldc_pins_t'(pinOut | pinOeLow);
endmodule : fldc_drive_model

`default_nettype wire

// File: test/test_floppy_logical_device_config.sv
// testbench for the floppy configuration bank, with a reference model
// assumes the drive model and the bound checker are compiled beside it
`timescale 1ns/1ps
`default_nettype none

module test_floppy_logical_device_config
  import fldc_pkg::*;
;
  logic          clock = 1'h0, reset = 1'h1;
  logic [7:0]    address = 8'h00, writeData = 8'h00, readData, driveTypeTable;
  logic          writeStrobe = 1'h0, readStrobe = 1'h0, hostIoWrite = 1'h0;
  fldc_target_t  hostIoTarget = FLDC_TGT_OTHER;
  fldc_core_t    core = '0;
  fldc_pins_t    pinOut, pinOeLow, lineLevel;
  logic          hostIoAccept, enhancedMode, burstDmaEnable, coreShutdown;
  logic          precompEnable0, precompEnable1;
  fldc_if_mode_t interfaceMode;
  logic [1:0]    mediaIdPolarity, bootDrive, rateTableSelect0, rateTableSelect1;
  int            failCount = 0, cmpCount = 0;
  int            regs [6];

  always #20 clock = ~clock;

  fldc_regs i_fldc_regs (.clock, .reset, .address, .writeData, .writeStrobe,
    .readStrobe, .readData, .hostIoWrite, .hostIoTarget, .hostIoAccept, .core,
    .pinOut, .pinOeLow, .enhancedMode, .burstDmaEnable, .interfaceMode,
    .coreShutdown, .mediaIdPolarity, .bootDrive, .driveTypeTable,
    .rateTableSelect0, .rateTableSelect1, .precompEnable0, .precompEnable1);
  fldc_drive_model i_fldc_drive_model (.pinOut, .pinOeLow, .lineLevel);

  // ----------------------------------------------------------------
  // checking, bus tasks and reference model
  // ----------------------------------------------------------------
  task automatic testDone();
    $display("compares %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : testDone

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] expRd(input logic [7:0] a);
    if (a >= 8'hF0 && a <= 8'hF5 && a != 8'hF3)
      return 8'(regs[a - 8'hF0]);
    return 8'h00;
  endfunction : expRd

  // write strobe stays up so writes may run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    address     <= a;
    writeData   <= d;
    writeStrobe <= 1'h1;
    readStrobe  <= 1'h0;
    case (a)
      8'hF0, 8'hF2: regs[a - 8'hF0] = d;
      8'hF1: regs[1] = d & 8'hFC;
      8'hF4, 8'hF5: regs[a - 8'hF0] = d & 8'h5B;
      default: ;
    endcase
    @(posedge clock);
  endtask : wr

  task automatic nop(input int n);
    writeStrobe <= 1'h0;
    readStrobe  <= 1'h0;
    repeat (n) @(posedge clock);
  endtask : nop

  task automatic rd(input logic [7:0] a);
    address     <= a;
    readStrobe  <= 1'h1;
    writeStrobe <= 1'h0;
    @(posedge clock);
    readStrobe <= 1'h0;
    @(negedge clock);
    chk("readData", readData, expRd(a));
    @(posedge clock);
  endtask : rd

  task automatic chkAll();
    for (int a = 8'hEF; a <= 8'hF7; a++)
      rd(8'(a));
    chk("enhancedMode", enhancedMode, regs[0][0]);
    chk("burstDma", burstDmaEnable, !regs[0][1]);
    chk("interfaceMode", interfaceMode, regs[0][3:2]);
    chk("coreShutdown", coreShutdown, regs[0][5]);
    chk("mediaId", mediaIdPolarity, regs[1][5:4]);
    chk("bootDrive", bootDrive, regs[1][7:6]);
    chk("typeTable", driveTypeTable, 8'(regs[2]));
    chk("rateTable0", rateTableSelect0, regs[4][4:3]);
    chk("rateTable1", rateTableSelect1, regs[5][4:3]);
    chk("precomp0", precompEnable0, !regs[4][6]);
    chk("precomp1", precompEnable1, !regs[5][6]);
  endtask : chkAll

  task automatic chkPins(input fldc_core_t c);
    logic       d;
    logic [1:0] dn, ds, ms;
    logic [7:0] m;
    m  = 8'(regs[0]);
    d  = regs[1][3] ? !regs[1][2] : c.densitySelect;
    ds = m[4] ? {c.driveSelectLow[0], c.driveSelectLow[1]} : c.driveSelectLow;
    ms = m[4] ? {c.motorOnLow[0], c.motorOnLow[1]} : c.motorOnLow;
    case (regs[c.driveIndex ? 5 : 4][1:0])
      0: dn = {d, c.rateBit0};
      1: dn = {c.rateBit1, c.rateBit0};
      2: dn = {!d, c.rateBit0};
      default: dn = {c.rateBit0, c.rateBit1};
    endcase
    @(negedge clock);
    chk("densityPins", {lineLevel.densityOutA, lineLevel.densityOutB},
        m[7] ? 2'h3 : dn);
    chk("selectPins", {lineLevel.driveSelectLow, lineLevel.motorOnLow},
        m[7] ? 4'hF : {ds, ms});
    chk("otherPins", lineLevel.otherOut,
        (m[7] | m[5]) ? 5'h1F : c.otherOut);
    @(posedge clock);
  endtask : chkPins

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    fldc_core_t c;
    logic       w;
    void'($urandom(87));
    regs = '{8'h0E, 0, 8'hFF, 0, 0, 0};
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    chkAll();
    repeat (40) wr(8'hF0 + 8'($urandom_range(7)), 8'($urandom));
    nop(1);
    chkAll();
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hF0, 8'($urandom) & 8'hF3 | 8'(i << 2));
      nop(1);
      chkAll();
    end
    for (int t = 0; t < 16; t++)
      for (int x = 0; x < 2; x++)
      begin
        c = fldc_core_t'($urandom);
        c.driveIndex = x[0];
        wr(8'hF4 + 8'(x), 8'($urandom) & 8'hFC | 8'(t[1:0]));
        wr(8'hF1, 8'($urandom) & 8'hF3 | 8'(t & 12));
        wr(8'hF0, 8'h40 | 8'($urandom) & 8'h1F);
        core <= c;
        nop(3);
        chkPins(c);
      end
    foreach (regs[k])
    begin
      c = fldc_core_t'($urandom);
      wr(8'hF0, 8'(k << 5) & 8'hA0 | 8'($urandom) & 8'h5F);
      core <= c;
      nop(3);
      chkPins(c);
      for (int g = 0; g < 8; g++)
      begin
        w = 1'($urandom);
        hostIoWrite  <= w;
        hostIoTarget <= fldc_target_t'(g);
        @(negedge clock);
        chk("hostIoAccept", hostIoAccept,
            w && (!regs[0][5] || g < 4));
        @(posedge clock);
      end
    end
    reset <= 1'h1;
    nop(2);
    reset <= 1'h0;
    regs = '{8'h0E, 0, 8'hFF, 0, 0, 0};
    nop(1);
    chkAll();
    testDone();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    failCount++;
    testDone();
  end
endmodule : test_floppy_logical_device_config

`default_nettype wire
